// ===== verilog/pfs_top.sv
/*
 * pwm forced output stop: two stop functions force two pwm outputs
 * into a safe state from comparator or interrupt-pin triggers.
 * assumes asynchronous trigger pins and an axi4-lite master.
 */
`timescale 1ns/1ns
// How it works
// - pin a or b triggers stop 2 when enabled
// - comparator 1/0 trigger stop 2 when selected
// - comparator 1/0 trigger stop 1 when selected
// - mode 0: stop 2 ends next period
// - mode 1: ends after reverse edge, period
// - clear 00: release write clears at once
// - clear 01: release ignored while trigger active
// - clear 10: release clears at next period
// - clear 11: idle release clears next period
// - stopped timer keeps pending stop active
// - safe state field picks output level
// - per-output trigger enable gates forcing
// - run bit cleared loads counter ffff
module pfs_top
   import pfs_pkg::*;
(
   input  wire logic        I_CLK,
   input  wire logic        I_RESET,
   input  wire logic [7:0]  I_AWADDR,
   input  wire logic        I_AWVALID,
   output logic             O_AWREADY,
   input  wire logic [31:0] I_WDATA,
   input  wire logic [3:0]  I_WSTRB,
   input  wire logic        I_WVALID,
   output logic             O_WREADY,
   output logic [1:0]       O_BRESP,
   output logic             O_BVALID,
   input  wire logic        I_BREADY,
   input  wire logic [7:0]  I_ARADDR,
   input  wire logic        I_ARVALID,
   output logic             O_ARREADY,
   output logic [31:0]      O_RDATA,
   output logic [1:0]       O_RRESP,
   output logic             O_RVALID,
   input  wire logic        I_RREADY,
   input  wire logic        I_COMPARATOR_ZERO,
   input  wire logic        I_COMPARATOR_ONE,
   input  wire logic        I_EXT_IRQ_PIN_A,
   input  wire logic        I_EXT_IRQ_PIN_B,
   output logic [1:0]       O_PWM_OUTPUT,
   output logic [1:0]       O_PWM_OUTPUT_OE_N
);
   import pfs_pkg::*;

   pfs_reg_if rif ();

   logic [3:0]  trig_s;
   logic        comparator_zero;
   logic        comparator_one;
   logic        pin_a;
   logic        pin_b;
   logic [15:0] ctrl_q;
   logic [7:0]  trgen_q;
   logic [15:0] period_q;
   logic [15:0] duty_q;
   logic        run_q;
   logic [15:0] cnt_q;
   logic        stop1_q;
   logic        pend1_q;
   logic        stop2_q;
   logic        rev2_q;
   logic        trig2_prev_q;
   logic        trig1;
   logic        trig2;
   logic        per_start;
   logic        rel;
   logic        rel_ok;
   logic        wr_ctrl;
   logic        wr_cmd;
   pfs_clr_t    clr_mode;
   logic        force_any;
   logic [1:0]  pwm_raw;
   logic        safe_lvl;
   logic        safe_hiz;
   logic [31:0] rd_mux;

   pfs_axil u_axil (
      .i_clk     (I_CLK),
      .i_reset   (I_RESET),
      .i_awaddr  (I_AWADDR),
      .i_awvalid (I_AWVALID),
      .o_awready (O_AWREADY),
      .i_wdata   (I_WDATA),
      .i_wstrb   (I_WSTRB),
      .i_wvalid  (I_WVALID),
      .o_wready  (O_WREADY),
      .o_bresp   (O_BRESP),
      .o_bvalid  (O_BVALID),
      .i_bready  (I_BREADY),
      .i_araddr  (I_ARADDR),
      .i_arvalid (I_ARVALID),
      .o_arready (O_ARREADY),
      .o_rdata   (O_RDATA),
      .o_rresp   (O_RRESP),
      .o_rvalid  (O_RVALID),
      .i_rready  (I_RREADY),
      .rif       (rif.bus)
   );

   pfs_sync #(.W(4)) u_sync (
      .i_clk   (I_CLK),
      .i_reset (I_RESET),
      .i_async ({I_EXT_IRQ_PIN_B, I_EXT_IRQ_PIN_A, I_COMPARATOR_ONE, I_COMPARATOR_ZERO}),
      .o_sync  (trig_s)
   );

   assign comparator_zero  = trig_s[0];
   assign comparator_one  = trig_s[1];
   assign pin_a = trig_s[2];
   assign pin_b = trig_s[3];

   // register writes
   assign wr_ctrl    = rif.wr_en && rif.wr_addr == OFF_CTRL;
   assign wr_cmd     = rif.wr_en && rif.wr_addr == OFF_CMD && rif.wr_strb[0];
   assign rel        = wr_cmd && rif.wr_data[B_RELEASE];
   assign rif.wr_ok  = pfs_mapped(rif.wr_addr);
   assign rif.rd_ok  = pfs_mapped(rif.rd_addr);
   assign clr_mode   = pfs_clr_t'(ctrl_q[B_S1_CLR +: 2]);

   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         ctrl_q   <= RST_CTRL;
         trgen_q  <= RST_TRGEN;
         period_q <= RST_PERIOD;
         duty_q   <= RST_DUTY;
         run_q    <= 1'b0;
      end else if (rif.wr_en) begin
         if (wr_ctrl)
            ctrl_q <= pfs_merge(ctrl_q, rif.wr_data, rif.wr_strb) & 16'hf13f;
         if (rif.wr_addr == OFF_TRGEN && rif.wr_strb[0])
            trgen_q <= {6'h00, rif.wr_data[1:0]};
         if (rif.wr_addr == OFF_PERIOD)
            period_q <= pfs_merge(period_q, rif.wr_data, rif.wr_strb);
         if (rif.wr_addr == OFF_DUTY)
            duty_q <= pfs_merge(duty_q, rif.wr_data, rif.wr_strb);
         if (wr_cmd)
            run_q <= rif.wr_data[B_RUN];
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RESET)
         cnt_q <= CNT_STOP;
      else if (!run_q)
         cnt_q <= CNT_STOP;
      else if (per_start)
         cnt_q <= 16'h0000;
      else
         cnt_q <= cnt_q + 16'h0001;
   end

   assign per_start = run_q && (cnt_q == period_q || cnt_q == CNT_STOP);

   assign trig1 = (ctrl_q[B_S1_COMPARATOR_ONE] && comparator_one) || (ctrl_q[B_S1_COMPARATOR_ZERO] && comparator_zero);

   // pins and comparators for stop 2
   assign trig2 = (ctrl_q[B_S2_PIN_B] && pin_b) || (ctrl_q[B_S2_PIN_A] && pin_a) ||
                  (ctrl_q[B_S2_COMPARATOR_ONE] && comparator_one) || (ctrl_q[B_S2_COMPARATOR_ZERO] && comparator_zero);

   assign rel_ok = rel && !(clr_mode[0] && trig1);

   // trigger set always beats release
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         stop1_q <= 1'b0;
      end else if (trig1) begin
         stop1_q <= 1'b1;
      end else begin
         unique case (clr_mode)
            CLR_NOW, CLR_NOW_IDLE: if (rel_ok) stop1_q <= 1'b0;
            CLR_PERIOD, CLR_PERIOD_IDLE: if (pend1_q && per_start) stop1_q <= 1'b0;
         endcase
      end
   end

   // pending clear armed by any release in mode 10, by idle release in mode 11
   // a release landing on a period start must not be lost, so it beats the drop
   always_ff @(posedge I_CLK) begin
      if (I_RESET)
         pend1_q <= 1'b0;
      else if (!clr_mode[1])
         pend1_q <= 1'b0;
      else if (rel_ok)
         pend1_q <= 1'b1;
      else if ((per_start && !trig1) || (!stop1_q && !trig1))
         pend1_q <= 1'b0;
   end

   // reverse edge of the trigger arms release
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         trig2_prev_q <= 1'b0;
         rev2_q       <= 1'b0;
      end else begin
         trig2_prev_q <= trig2;
         if (trig2)
            rev2_q <= 1'b0;
         else if (trig2_prev_q)
            rev2_q <= 1'b1;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (I_RESET)
         stop2_q <= 1'b0;
      else if (trig2)
         stop2_q <= 1'b1;
      else if (per_start && (!ctrl_q[B_S2_MODE] || rev2_q))
         stop2_q <= 1'b0;
   end

   // plain pwm: output 1 is the complement of output 0
   assign pwm_raw = {!(cnt_q < duty_q), cnt_q < duty_q};

   // live trigger forces at once, not one cycle late
   assign force_any = stop1_q || trig1 || stop2_q || trig2;

   // stop 1 alone can pick hi-z; both stops share the level
   always_comb begin
      safe_hiz = 1'b0;
      safe_lvl = ctrl_q[B_SAFE];
      if (stop1_q || trig1)
         safe_hiz = !ctrl_q[B_SAFE + 1];
   end

   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         O_PWM_OUTPUT      <= 2'b00;
         O_PWM_OUTPUT_OE_N <= 2'b00;
      end else begin
         for (int n = 0; n < 2; n++) begin
            if (trgen_q[n] && force_any) begin
               O_PWM_OUTPUT[n]      <= safe_hiz ? 1'b0 : safe_lvl;
               O_PWM_OUTPUT_OE_N[n] <= safe_hiz;
            end else begin
               O_PWM_OUTPUT[n]      <= pwm_raw[n];
               O_PWM_OUTPUT_OE_N[n] <= 1'b0;
            end
         end
      end
   end

   // read mux; unmapped addresses read zero with slverr
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (rif.rd_addr)
         OFF_CTRL:   rd_mux[15:0] = ctrl_q;
         OFF_TRGEN:  rd_mux[7:0]  = trgen_q;
         OFF_PERIOD: rd_mux[15:0] = period_q;
         OFF_DUTY:   rd_mux[15:0] = duty_q;
         OFF_CMD:    rd_mux[0]    = run_q;
         OFF_STATUS: rd_mux[9:0]  = {trig_s, rev2_q, pend1_q, stop2_q, stop1_q, trig2, trig1};
         OFF_COUNT:  rd_mux[15:0] = cnt_q;
         default:    rd_mux = 32'h0000_0000;
      endcase
   end
   assign rif.rd_data = rd_mux;

   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RESET);

   chk_pin_trig_stop2: assert property (
      ctrl_q[B_S2_PIN_A] && pin_a |=> stop2_q)
      else $error("pin a trigger did not set stop 2");

   chk_comp_trig_stop2: assert property (
      ctrl_q[B_S2_COMPARATOR_ONE] && comparator_one |=> stop2_q)
      else $error("comparator 1 did not set stop 2");

   chk_comp_trig_stop1: assert property (
      ctrl_q[B_S1_COMPARATOR_ZERO] && comparator_zero |=> stop1_q)
      else $error("comparator 0 did not set stop 1");

   chk_mode0_period_clear: assert property (
      stop2_q && !ctrl_q[B_S2_MODE] && per_start && !trig2 |=> !stop2_q)
      else $error("stop 2 not cleared at period start");

   chk_mode1_hold: assert property (
      stop2_q && ctrl_q[B_S2_MODE] && !rev2_q |=> stop2_q)
      else $error("stop 2 left before reverse edge");

   chk_clear_now: assert property (
      clr_mode == CLR_NOW && rel && !trig1 |=> !stop1_q)
      else $error("release did not clear stop 1");

   chk_clear_refused: assert property (
      clr_mode == CLR_NOW_IDLE && rel && trig1 |=> stop1_q)
      else $error("release accepted while trigger active");

   chk_clear_deferred: assert property (
      clr_mode == CLR_PERIOD && rel && stop1_q && !per_start && !trig1 |=> pend1_q && stop1_q)
      else $error("deferred release not pending");

   chk_clear_idle_deferred: assert property (
      clr_mode == CLR_PERIOD_IDLE && rel && trig1 && !pend1_q |=> !pend1_q)
      else $error("release during active trigger armed clear");

   chk_stopped_holds: assert property (
      !run_q && stop1_q && clr_mode[1] && !wr_ctrl |=> stop1_q)
      else $error("stop 1 cleared while timer stopped");

   chk_hiz_state: assert property (
      trgen_q[0] && stop1_q && !ctrl_q[B_SAFE + 1] |=> O_PWM_OUTPUT_OE_N[0])
      else $error("stop 1 safe state not hi-z");

   chk_gate_off: assert property (
      !trgen_q[0] |=> !O_PWM_OUTPUT_OE_N[0])
      else $error("disabled output was forced");

   chk_stop_loads_ffff: assert property (
      !run_q |=> cnt_q == CNT_STOP)
      else $error("stopped counter not ffff");

   chk_trigger_to_pin: assert property (
      trgen_q[1] && trig1 && ctrl_q[1:0] == 2'b11 |=> O_PWM_OUTPUT[1] && !O_PWM_OUTPUT_OE_N[1])
      else $error("safe high not applied");

   cov_stop1_released: cover property (stop1_q ##1 !stop1_q);
   cov_stop2_reverse: cover property (stop2_q && rev2_q && per_start);
   cov_refused_release: cover property (rel && trig1 && clr_mode[0]);
endmodule : pfs_top

// ===== verilog/pfs_pkg.sv
/*
 * constants, register map and helpers for the pwm forced output stop block.
 * assumes a 32-bit axi4-lite register bus with 8-bit byte addresses.
 */
package pfs_pkg;
   localparam int AW = 8;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_TRGEN  = 8'h04;
   localparam logic [7:0] OFF_PERIOD = 8'h08;
   localparam logic [7:0] OFF_DUTY   = 8'h0c;
   localparam logic [7:0] OFF_CMD    = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;
   localparam logic [7:0] OFF_COUNT  = 8'h18;
   // forced_stop_control fields
   localparam int B_S2_PIN_B = 15;
   localparam int B_S2_PIN_A = 14;
   localparam int B_S2_COMPARATOR_ONE  = 13;
   localparam int B_S2_COMPARATOR_ZERO  = 12;
   localparam int B_S2_MODE  = 8;
   localparam int B_S1_COMPARATOR_ONE  = 5;
   localparam int B_S1_COMPARATOR_ZERO  = 4;
   localparam int B_S1_CLR   = 2;
   localparam int B_SAFE     = 0;
   // command register fields
   localparam int B_RUN      = 0;
   localparam int B_RELEASE  = 1;
   // reset values
   localparam logic [15:0] RST_CTRL   = 16'h411c;
   localparam logic [7:0]  RST_TRGEN  = 8'h02;
   localparam logic [15:0] RST_PERIOD = 16'hffff;
   localparam logic [15:0] RST_DUTY   = 16'h8000;
   localparam logic [15:0] CNT_STOP   = 16'hffff;
   // stop function 1 clear conditions
   typedef enum logic [1:0] {
      CLR_NOW, CLR_NOW_IDLE, CLR_PERIOD, CLR_PERIOD_IDLE
   } pfs_clr_t;

   function automatic logic pfs_mapped(input logic [7:0] a);
      return a == OFF_CTRL || a == OFF_TRGEN || a == OFF_PERIOD ||
             a == OFF_DUTY || a == OFF_CMD || a == OFF_STATUS ||
             a == OFF_COUNT;
   endfunction : pfs_mapped

   function automatic logic [15:0] pfs_merge(input logic [15:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  strb);
      return {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
   endfunction : pfs_merge
endpackage : pfs_pkg

// ===== verilog/pfs_reg_if.sv
/*
 * register access carrier between the bus slave and the core.
 * assumes one clock; writes are single-cycle pulses.
 */
`timescale 1ns/1ns
interface pfs_reg_if;
   logic        wr_en;
   logic [7:0]  wr_addr;
   logic [31:0] wr_data;
   logic [3:0]  wr_strb;
   logic        wr_ok;
   logic [7:0]  rd_addr;
   logic [31:0] rd_data;
   logic        rd_ok;
   modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_addr, input wr_ok, rd_data, rd_ok);
   modport core (input wr_en, wr_addr, wr_data, wr_strb, rd_addr, output wr_ok, rd_data, rd_ok);
endinterface : pfs_reg_if

// ===== verilog/pfs_sync.sv
/*
 * two-flop synchroniser for asynchronous trigger pins.
 * assumes inputs are slow levels relative to the clock.
 */
`timescale 1ns/1ns
module pfs_sync #(
   parameter int W = 4
) (
   input  wire logic         i_clk,
   input  wire logic         i_reset,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   logic [W-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         meta_q <= '0;
         o_sync <= '0;
      end else begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end
endmodule : pfs_sync

// ===== verilog/pfs_axil.sv
/*
 * axi4-lite slave feeding the register carrier.
 * assumes one write and one read outstanding at a time.
 */
`timescale 1ns/1ns
module pfs_axil (
   input  wire logic        i_clk,
   input  wire logic        i_reset,
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   output logic [1:0]       o_bresp,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   input  wire logic [7:0]  i_araddr,
   input  wire logic        i_arvalid,
   output logic             o_arready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   pfs_reg_if.bus           rif
);
   logic aw_h_q;
   logic w_h_q;

   assign o_awready   = !aw_h_q;
   assign o_wready    = !w_h_q;
   assign o_arready   = !o_rvalid;
   assign rif.wr_en   = aw_h_q && w_h_q && !o_bvalid;
   assign rif.rd_addr = i_araddr;

   // address and data may arrive in either order
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         aw_h_q      <= 1'b0;
         w_h_q       <= 1'b0;
         rif.wr_addr <= 8'h00;
         rif.wr_data <= 32'h0000_0000;
         rif.wr_strb <= 4'h0;
      end else begin
         if (rif.wr_en) begin
            aw_h_q <= 1'b0;
            w_h_q  <= 1'b0;
         end else begin
            if (i_awvalid && !aw_h_q) begin
               aw_h_q      <= 1'b1;
               rif.wr_addr <= i_awaddr;
            end
            if (i_wvalid && !w_h_q) begin
               w_h_q       <= 1'b1;
               rif.wr_data <= i_wdata;
               rif.wr_strb <= i_wstrb;
            end
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_bvalid <= 1'b0;
         o_bresp  <= 2'b00;
      end else if (rif.wr_en) begin
         o_bvalid <= 1'b1;
         o_bresp  <= rif.wr_ok ? 2'b00 : 2'b10;
      end else if (i_bready) begin
         o_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_rvalid <= 1'b0;
         o_rdata  <= 32'h0000_0000;
         o_rresp  <= 2'b00;
      end else if (i_arvalid && !o_rvalid) begin
         o_rvalid <= 1'b1;
         o_rdata  <= rif.rd_data;
         o_rresp  <= rif.rd_ok ? 2'b00 : 2'b10;
      end else if (i_rready) begin
         o_rvalid <= 1'b0;
      end
   end
endmodule : pfs_axil

// ===== dv/pfs_trig_model.sv
/*
 * far-side model: analog comparators and interrupt pins feeding the stop block.
 * assumes the bench commands levels; edges land off the clock grid on purpose.
 */
`timescale 1ns/1ns
module pfs_trig_model (
   input  wire logic [3:0] i_req,
   output logic            o_cmp_zero,
   output logic            o_cmp_one,
   output logic            o_pin_a,
   output logic            o_pin_b
);
   logic [3:0] lvl_q = 4'h0;
   // real comparators are not clocked, so levels move 3 ns after the command
   always @(i_req) begin
      lvl_q <= #3 i_req;
   end
   assign o_cmp_zero = lvl_q[0];
   assign o_cmp_one  = lvl_q[1];
   assign o_pin_a    = lvl_q[2];
   assign o_pin_b    = lvl_q[3];
endmodule : pfs_trig_model

// ===== dv/testbench.sv
/*
 * self-checking bench for the pwm forced output stop block.
 * assumes pfs_top with its axi4-lite slave and the trigger model beside it.
 */
`timescale 1ns/1ns
module testbench;
   import pfs_pkg::*;
   logic        clk = 1'b0, rst = 1'b1;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0, rdata, d, ctrl;
   logic [3:0]  wstrb = 4'hf, trig_req = 4'h0, src;
   logic [1:0]  bresp, rresp, pwm, oe_n, r;
   logic        awready, wready, bvalid, arready, rvalid, comparator_zero, comparator_one, pa, pb;
   int          mismatches = 0, checks_done = 0;
   logic [7:0]  ra [6] = '{OFF_CTRL, OFF_TRGEN, OFF_PERIOD, OFF_DUTY, OFF_CMD, OFF_COUNT};
   logic [31:0] rv [6] = '{{16'h0, RST_CTRL}, {24'h0, RST_TRGEN}, {16'h0, RST_PERIOD},
                           {16'h0, RST_DUTY}, 32'h0, {16'h0, CNT_STOP}};

   always #5 clk = ~clk;

   pfs_trig_model pfs_trig_model_inst (.i_req(trig_req), .o_cmp_zero(comparator_zero), .o_cmp_one(comparator_one),
                                       .o_pin_a(pa), .o_pin_b(pb));
   pfs_top pfs_top_inst (
      .I_CLK(clk), .I_RESET(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
      .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
      .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid),
      .O_ARREADY(arready), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
      .I_COMPARATOR_ZERO(comparator_zero), .I_COMPARATOR_ONE(comparator_one), .I_EXT_IRQ_PIN_A(pa),
      .I_EXT_IRQ_PIN_B(pb), .O_PWM_OUTPUT(pwm), .O_PWM_OUTPUT_OE_N(oe_n));

   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : complete_run

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : cmp

   task automatic ran_out();
      mismatches++;
      $display("BAD %0t wait ran out", $time);
      complete_run();
   endtask : ran_out

   // ready is combinational from state, so the falling edge shows what the next rising edge samples
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
      logic aw_p, w_p, ha, hw, hit;
      int   n;
      @(posedge clk);
      awaddr  <= a;
      wdata   <= v;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      aw_p = 1'b1;
      w_p  = 1'b1;
      n    = 0;
      hit  = 1'b0;
      while (aw_p || w_p) begin
         @(negedge clk);
         ha = aw_p && awready;
         hw = w_p && wready;
         @(posedge clk);
         if (ha) begin
            awvalid <= 1'b0;
            aw_p = 1'b0;
         end
         if (hw) begin
            wvalid <= 1'b0;
            w_p = 1'b0;
         end
         n++;
         if (n > 100) ran_out();
      end
      bready <= 1'b1;
      while (!hit) begin
         @(negedge clk);
         hit  = bvalid;
         resp = bresp;
         @(posedge clk);
         n++;
         if (n > 200) ran_out();
      end
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
      logic hit;
      int   n;
      @(posedge clk);
      araddr  <= a;
      arvalid <= 1'b1;
      n   = 0;
      hit = 1'b0;
      while (!hit) begin
         @(negedge clk);
         hit = arready;
         @(posedge clk);
         n++;
         if (n > 100) ran_out();
      end
      arvalid <= 1'b0;
      rready  <= 1'b1;
      hit = 1'b0;
      while (!hit) begin
         @(negedge clk);
         hit  = rvalid;
         v    = rdata;
         resp = rresp;
         @(posedge clk);
         n++;
         if (n > 200) ran_out();
      end
      rready <= 1'b0;
   endtask : rd

   task automatic setr(input logic [7:0] a, input logic [31:0] v);
      logic [1:0] rs;
      wr(a, v, rs);
      cmp({30'h0, rs}, 32'h0, "write response");
   endtask : setr

   // e = {pending release, stop 2, stop 1}
   task automatic st(input logic [2:0] e);
      rd(OFF_STATUS, d, r);
      cmp({29'h0, d[4:2]}, {29'h0, e}, "stop flags");
   endtask : st

   // pins are registered, so look at them away from the edge that launches them
   task automatic outs(input logic [1:0] o, input logic [1:0] oe);
      @(negedge clk);
      cmp({28'h0, oe_n, pwm & ~oe}, {28'h0, oe, o & ~oe}, "pwm pins");
   endtask : outs

   // three edges reach the output, five leave margin for the unaligned pin edge
   task automatic trig(input logic [3:0] v);
      @(posedge clk);
      trig_req <= v;
      repeat (5) @(posedge clk);
   endtask : trig

   function automatic logic [2:0] exp_stop(input logic [31:0] c, input logic [3:0] s);
      return {1'b0, |(s & c[15:12]), |(s[1:0] & c[5:4])};
   endfunction : exp_stop

   initial begin
      repeat (100000) @(posedge clk);
      ran_out();
   end

   initial begin
      void'($urandom(52));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         rd(ra[i], d, r);
         cmp(d, rv[i], "reset value");
      end
      rd(8'h1c, d, r);
      cmp({r, d[29:0]}, 32'h80000000, "unmapped read");
      wr(8'h1c, 32'h1, r);
      cmp({30'h0, r}, 32'h2, "unmapped write");
      outs(2'b10, 2'b00);
      setr(OFF_TRGEN, 32'h3);
      for (int s = 0; s < 4; s++) begin
         setr(OFF_CTRL, 32'h0010 | s);
         trig(4'h1);
         outs(s[1] ? {2{s[0]}} : 2'b00, s[1] ? 2'b00 : 2'b11);
         trig(4'h0);
         setr(OFF_CMD, 32'h2);
         st(3'b000);
         setr(OFF_CTRL, 32'h4000 | s);
         trig(4'h4);
         outs({2{s[0]}}, 2'b00);
         trig(4'h0);
         setr(OFF_CMD, 32'h1);
         setr(OFF_CMD, 32'h0);
         st(3'b000);
      end
      for (int g = 0; g < 4; g++) begin
         setr(OFF_TRGEN, g);
         setr(OFF_CTRL, 32'h0010);
         trig(4'h1);
         outs(2'b10, g[1:0]);
         trig(4'h0);
         setr(OFF_CMD, 32'h2);
      end
      setr(OFF_TRGEN, 32'h3);
      for (int m = 0; m < 4; m++) begin
         setr(OFF_CTRL, 32'h0010 | (m << 2));
         trig(4'h1);
         setr(OFF_CMD, 32'h2);
         trig(4'h0);
         st({m == 2, 2'b01});
         setr(OFF_CMD, 32'h2);
         st({m >= 2, 1'b0, m >= 2});
         setr(OFF_CMD, 32'h1);
         setr(OFF_CMD, 32'h0);
         st(3'b000);
         rd(OFF_COUNT, d, r);
         cmp(d, {16'h0, CNT_STOP}, "stopped count");
      end
      setr(OFF_PERIOD, 32'h7);
      setr(OFF_CTRL, 32'h2100);
      setr(OFF_CMD, 32'h1);
      trig(4'h2);
      repeat (30) @(posedge clk);
      st(3'b010);
      outs(2'b00, 2'b00);
      trig(4'h0);
      repeat (20) @(posedge clk);
      st(3'b000);
      setr(OFF_CMD, 32'h0);
      for (int k = 0; k < 12; k++) begin
         ctrl = ($urandom & 32'hf030) | 32'h3;
         src = 4'h1 << ($urandom % 4);
         setr(OFF_CTRL, ctrl);
         trig(src);
         st(exp_stop(ctrl, src));
         trig(4'h0);
         setr(OFF_CMD, 32'h2);
         setr(OFF_CMD, 32'h1);
         setr(OFF_CMD, 32'h0);
         st(3'b000);
      end
      complete_run();
   end
endmodule : testbench
